// *** atten_ctrl_pkg.sv ***
// Package: constants and types for the step attenuator controller
`default_nettype none
package atten_ctrl_pkg;
  localparam int WORD_BITS = 6;
  localparam logic [5:0] WORD_MAX = 6'h3F;
  localparam int CLK_PERIOD_NS = 10;
  // Serial clock max 10 MHz: half period 50 ns least
  localparam int SCLK_HALF_NS = 50;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Setup of data / strobe, 10 ns least
  localparam int SETUP_NS = 10;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe pulse width, 30 ns least (serial bound covers parallel)
  localparam int STROBE_NS = 30;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Serial to parallel mode setup, 100 ns least
  localparam int MODE_NS = 100;
  localparam int MODE_CYC = (MODE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;

  typedef enum logic [1:0] {
    MODE_SERIAL,
    MODE_LATCHED,
    MODE_DIRECT
  } mode_t;

  typedef struct packed {
    logic mode_serial;
    logic strobe;
    logic sdata;
    logic sclk;
    logic [5:0] word;
  } pins_t;
endpackage : atten_ctrl_pkg
`default_nettype wire

// *** atten_wait.sv ***
// Wait counter: pulses done after a loaded cycle count
`default_nettype none
module atten_wait
  import atten_ctrl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic load_in,
  input wire logic [CNT_W-1:0] count_in,
  output logic done_out
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_done = 1'b0;
    if (load_in) begin
      next_cnt = count_in;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_done = (cnt == CNT_W'(1));
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      cnt <= '0;
      done_out <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done_out <= next_done;
    end
  end
endmodule : atten_wait
`default_nettype wire

// *** atten_ctrl.sv ***
// Controller that programs a 6-bit step attenuator over its control pins
// Summary of operation
// RULE1: Device latches shift register on strobe rise
// RULE2: Shift word most significant bit first
// RULE3: Bit weights 16 down to 0.5 dB
// RULE4: Device powers up at maximum attenuation
// RULE5: Direct mode presets state before power-up
// RULE6: Hold strobe high during direct mode; a direct request drops it until ST_SETUP ends
// RULE7: Direct mode follows parallel inputs immediately
// RULE8: Latched mode: select low, strobe low, then data
// RULE9: Device ignores parallel inputs while strobe low
// RULE10: Strobe rise applies parallel word
// RULE11: Strobe returns low; device holds word
// RULE12: Mode pin high serial, low parallel
// RULE13: One bit per serial clock rising edge
// RULE14: Strobe low while shifting serial word
// RULE15: Parallel inputs ignored in serial mode
`default_nettype none
module atten_ctrl
  import atten_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // User request and status
  input wire logic REQ_IN,
  input wire logic [1:0] MODE_IN,
  input wire logic [WORD_BITS-1:0] WORD_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  // Device control pins
  output logic MODE_SEL_OUT,
  output logic LATCH_STROBE_OUT,
  output logic SERIAL_DATA_IN_OUT,
  output logic SERIAL_CLK_OUT,
  output logic [WORD_BITS-1:0] ATTEN_WORD_OUT
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_MODE, ST_SETUP, ST_CLK_LO, ST_CLK_HI, ST_STROBE, ST_DONE
  } state_t;

  state_t state;
  state_t next_state;
  pins_t pins;
  pins_t next_pins;
  mode_t mode;
  mode_t next_mode;
  logic [WORD_BITS-1:0] shreg;
  logic [WORD_BITS-1:0] next_shreg;
  logic [2:0] bits;
  logic [2:0] next_bits;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;
  logic wait_load;
  logic [CNT_W-1:0] wait_count;
  logic wait_done;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction : cyc

  atten_wait u_wait (
    .CLK_IN(CLK_IN),
    .RESET_IN(RESET_IN),
    .load_in(wait_load),
    .count_in(wait_count),
    .done_out(wait_done)
  );

  always_comb begin
    next_state = state;
    next_pins = pins;
    next_mode = mode;
    next_shreg = shreg;
    next_bits = bits;
    next_busy = busy;
    next_done = 1'b0;
    wait_load = 1'b0;
    wait_count = '0;
    case (state)
      ST_IDLE: begin
        if (REQ_IN) begin
          next_busy = 1'b1;
          next_mode = (MODE_IN == 2'h2) ? MODE_DIRECT :
                      (MODE_IN == 2'h1) ? MODE_LATCHED : MODE_SERIAL;
          next_shreg = WORD_IN;
          next_pins.mode_serial = (next_mode == MODE_SERIAL); // RULE12
          next_pins.strobe = 1'b0; // RULE8 RULE14
          next_pins.sclk = 1'b0;
          wait_load = 1'b1;
          wait_count = cyc(MODE_CYC);
          next_state = ST_MODE;
        end
      end
      ST_MODE: begin
        if (wait_done) begin
          if (mode == MODE_SERIAL) begin
            next_pins.word = '0; // RULE15
            next_pins.sdata = shreg[WORD_BITS-1]; // RULE2
            next_bits = 3'h0;
          end else begin
            next_pins.word = shreg; // RULE8
          end
          wait_load = 1'b1;
          wait_count = cyc(SETUP_CYC);
          next_state = (mode == MODE_SERIAL) ? ST_CLK_LO : ST_SETUP;
        end
      end
      ST_CLK_LO: begin
        if (wait_done) begin
          next_pins.sclk = 1'b1; // RULE13
          wait_load = 1'b1;
          wait_count = cyc(SCLK_HALF_CYC);
          next_state = ST_CLK_HI;
        end
      end
      ST_CLK_HI: begin
        if (wait_done) begin
          next_pins.sclk = 1'b0;
          next_bits = bits + 3'h1;
          next_shreg = {shreg[WORD_BITS-2:0], 1'b0}; // RULE2
          next_pins.sdata = shreg[WORD_BITS-2];
          wait_load = 1'b1;
          wait_count = cyc(SCLK_HALF_CYC);
          next_state = (bits == 3'h5) ? ST_SETUP : ST_CLK_LO;
        end
      end
      ST_SETUP: begin
        if (wait_done) begin
          next_pins.strobe = 1'b1; // RULE1 RULE10 RULE6
          wait_load = 1'b1;
          wait_count = cyc(STROBE_CYC);
          next_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        // Direct mode leaves the strobe high so the word drives the state
        if (wait_done) begin
          if (mode != MODE_DIRECT) begin
            next_pins.strobe = 1'b0; // RULE11
          end
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Reset drives strobe low and mode serial: device stays at its
  // maximum-attenuation power-up state until a word is latched
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      state <= ST_IDLE;
      pins <= '{mode_serial: 1'b1, strobe: 1'b0, sdata: 1'b0, sclk: 1'b0,
                word: 6'h00}; // RULE4
      mode <= MODE_SERIAL;
      shreg <= 6'h00;
      bits <= 3'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      mode <= next_mode;
      shreg <= next_shreg;
      bits <= next_bits;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign MODE_SEL_OUT = pins.mode_serial;
  assign LATCH_STROBE_OUT = pins.strobe;
  assign SERIAL_DATA_IN_OUT = pins.sdata;
  assign SERIAL_CLK_OUT = pins.sclk;
  assign ATTEN_WORD_OUT = pins.word;
  assign BUSY_OUT = busy;
  assign DONE_OUT = done;

  a_no_clk_strobe: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE14
    pins.strobe |-> !$rose(pins.sclk)) else $error("clock while strobe high");
  a_par_data_stable: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE8
    (pins.strobe && mode == MODE_LATCHED) |-> $stable(pins.word))
    else $error("word changed with strobe high");
  a_serial_word_zero: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE15
    $rose(pins.sclk) |-> pins.word == 6'h00 && pins.mode_serial)
    else $error("parallel pins not grounded in serial");
  a_strobe_width: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE11
    ($rose(pins.strobe) && mode != MODE_DIRECT) |-> pins.strobe [*3])
    else $error("strobe too short");
  a_direct_hold: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE6
    (state == ST_DONE && mode == MODE_DIRECT) |=> pins.strobe)
    else $error("strobe dropped in direct");
  a_mode_pin: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE12
    (state == ST_SETUP) |-> pins.mode_serial == (mode == MODE_SERIAL))
    else $error("mode pin wrong");
  a_six_clocks: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE13
    (state == ST_SETUP && mode == MODE_SERIAL) |-> bits == 3'h6)
    else $error("bit count wrong");
  a_done_pulse: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE1
    done |=> !done && !busy) else $error("done not single");
  a_latched_order: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE8
    (mode == MODE_LATCHED && !$stable(pins.word)) |-> !pins.strobe && !pins.mode_serial)
    else $error("parallel word changed out of order");
  a_shift_strobe_low: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE14
    (state == ST_CLK_LO || state == ST_CLK_HI) |-> !pins.strobe)
    else $error("strobe high while shifting");
  a_idle_word_hold: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE11
    (state == ST_IDLE) |=> $stable(pins.word))
    else $error("word moved while idle");
  a_data_hold: assert property (@(posedge CLK_IN) disable iff (RESET_IN) // RULE2
    pins.sclk |-> $stable(pins.sdata))
    else $error("serial data moved with clock high");
endmodule : atten_ctrl
`default_nettype wire

// *** atten_dev_model.sv ***
// Behavioural model of the attenuator's control pins and state
`default_nettype none
module atten_dev_model
  import atten_ctrl_pkg::*;
(
  // Control pins
  input wire logic mode_sel_in,
  input wire logic strobe_in,
  input wire logic sdata_in,
  input wire logic sclk_in,
  input wire logic [WORD_BITS-1:0] word_in,
  // Active state, bit5 16 dB down to bit0 0.5 dB
  output logic [WORD_BITS-1:0] state_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WORD_BITS-1:0] shift_reg;
  initial begin
    shift_reg = WORD_MAX;
    state_out = WORD_MAX;
    // Direct preset at power-up; the settling delay is not modelled
    #1;
    if (!mode_sel_in && strobe_in) begin
      state_out = word_in;
    end
  end
  always @(posedge sclk_in) begin
    if (mode_sel_in && !strobe_in) begin
      shift_reg = {shift_reg[WORD_BITS-2:0], sdata_in};
    end
  end
  // Parallel word never reaches the serial path
  always @(posedge strobe_in) begin
    if (mode_sel_in) begin
      state_out = shift_reg;
    end
  end
  // Parallel mode: transparent while strobe high, frozen while low
  always @(strobe_in or word_in or mode_sel_in) begin
    if (!mode_sel_in && strobe_in) begin
      state_out = word_in;
    end
  end
endmodule : atten_dev_model
`default_nettype wire

// *** atten_ctrl_tb.sv ***
// Self-checking testbench of the attenuator controller
`default_nettype none
module atten_ctrl_tb
  import atten_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, req, busy, done, mode_sel, strobe, sdata, sclk;
  logic [1:0] mode;
  logic [5:0] word, pins, dev_state, rnd_word;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int sclk_edges = 0;
  int seed = 32'h1a2dc0a2;
  int exp_q[$];
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  atten_ctrl atten_ctrl_i (.CLK_IN(clk), .RESET_IN(rst), .REQ_IN(req), .MODE_IN(mode),
    .WORD_IN(word), .BUSY_OUT(busy), .DONE_OUT(done), .MODE_SEL_OUT(mode_sel),
    .LATCH_STROBE_OUT(strobe), .SERIAL_DATA_IN_OUT(sdata), .SERIAL_CLK_OUT(sclk),
    .ATTEN_WORD_OUT(pins));
  atten_dev_model atten_dev_model_i (.mode_sel_in(mode_sel), .strobe_in(strobe),
    .sdata_in(sdata), .sclk_in(sclk), .word_in(pins), .state_out(dev_state));
  always @(posedge sclk) sclk_edges++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    total_checks++;
    if (seen !== expected) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // Poke raises a second request while busy; it must be dropped
  task automatic run_op(input logic [1:0] m, input logic [5:0] w, input logic poke);
    int n;
    n = 0;
    sclk_edges = 0;
    @(negedge clk);
    req = 1'h1;
    mode = m;
    word = w;
    @(negedge clk);
    check(8'({busy, strobe}), 8'h02);
    req = poke;
    word = ~w;
    @(negedge clk);
    req = 1'h0;
    while (done !== 1'h1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(8'(n < 200), 8'h01);
    check(8'(busy), 8'h00);
    check(8'(sclk_edges), (m == 2'h1 || m == 2'h2) ? 8'h00 : 8'h06);
    exp_q.push_back(int'(w));
    check(8'(dev_state), 8'(exp_q.pop_front()));
    check(8'(mode_sel), 8'(m != 2'h1 && m != 2'h2));
    check(8'(strobe), 8'(m == 2'h2));
    if (mode_sel === 1'h1) begin
      check(8'(pins), 8'h00);
    end
  endtask : run_op
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'h1;
    req = 1'h0;
    mode = 2'h0;
    word = 6'h00;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    check(8'(dev_state), 8'(WORD_MAX));
    check(8'(mode_sel), 8'h01);
    // Direct then serial forces the strobe to fall before shifting
    for (int i = 0; i < 16; i++) begin
      rnd_word = 6'($random(seed));
      if (i < 4) rnd_word = i[0] ? WORD_MAX : 6'h00;
      run_op(2'(i % 4), rnd_word, i[2]);
    end
    // Reset between operations: pins fall back to idle, device keeps its word
    rnd_word = dev_state;
    rst = 1'h1;
    repeat (2) @(negedge clk);
    check(8'({mode_sel, strobe, sclk, busy}), 8'h08);
    rst = 1'h0;
    check(8'(dev_state), 8'(rnd_word));
    run_op(2'h1, 6'($random(seed)), 1'h0);
    report_and_stop();
  end
endmodule : atten_ctrl_tb
`default_nettype wire
